// ==== pkg/fmt_pkg.sv ====
// Purpose: Shared constants for the sample block output formatter.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Offsets are byte addresses on the register bus.
//
// Overview of operation
// - Output resolution selectable, 12 or 24 bits.
// - Block size request from 2 to 2/3 memory.
// - Invalid block size keeps old, flags bit 6.
// - Block size updates once setup becomes valid.
// - Block counts reals or complex pairs.
// - Size limits depend on type and resolution.
// - Block size is always even.
// - Block available may need extra samples.
// - Block size readback gives value in use.
// - Minimum FIFO delay, continuous mode only.
// - Real output emits real component only.
// - Complex output emits real then imaginary.
// - Parity bits used: 18 Mbyte FIFO capacity.
// - Settings behave alike on every output port.
// - Block mode stops after each block; rearm.
// - Continuous mode runs until FIFO overflow.
// - Default port is backplane register reads.

package fmt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_BLKSIZE = 8'h04;
  localparam logic [7:0] REG_DELAY = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam logic [7:0] REG_CONTROL = 8'h14;

  localparam int CFG_COMPLEX_BIT = 0;
  localparam int CFG_RES24_BIT = 1;
  localparam int CFG_CONT_BIT = 2;
  localparam int CFG_LOCAL_BIT = 3;
  localparam int ST_AVAIL_BIT = 0;
  localparam int ST_ARMED_BIT = 1;
  localparam int ST_RUN_BIT = 2;
  localparam int ST_OVF_BIT = 3;
  localparam int ST_DATA_BIT = 4;
  localparam int ST_SETUP_ERR_BIT = 6;
  localparam int CTL_ARM_BIT = 0;
  localparam int CTL_TRIG_BIT = 1;

  // ----------------------------------------------------------------
  // Sizes and limits
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 24;
  localparam int BS_W = 25;
  localparam int DLY_W = 24;
  localparam int FIFO_DEPTH_DEF = 4;
  localparam int MEM_BYTES = 18 * 1024 * 1024;
  localparam logic [BS_W-1:0] BS_ABS_MIN = 25'h000_0002;
  localparam logic [BS_W-1:0] BS_ABS_MAX = BS_W'(MEM_BYTES / 3 * 2);
  localparam logic [BS_W-1:0] BS_MIN_R12 = 25'h000_0006;
  localparam logic [BS_W-1:0] BS_MAX_R12 = 25'h0C0_0000;
  localparam logic [BS_W-1:0] BS_MIN_MID = 25'h000_0003;
  localparam logic [BS_W-1:0] BS_MAX_MID = 25'h060_0000;
  localparam logic [BS_W-1:0] BS_MIN_C24 = 25'h000_0002;
  localparam logic [BS_W-1:0] BS_MAX_C24 = 25'h030_0000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [BS_W-1:0] BS_RESET = 25'h000_0400;
  localparam logic [DLY_W-1:0] DELAY_MIN_DEF = 24'h00_0010;
  localparam logic [DLY_W-1:0] DELAY_MAX_DEF = 24'h10_0000;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_ARMED = 2'b01,
    ACQ_RUN = 2'b10
  } acq_state_t;

endpackage

// ==== verilog/pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for a pin.
// Assumes: Input is asynchronous to sys_clk.
// Notes: Output changes only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pin,
  output logic level
);
  logic s1_q, s2_q, s3_q, level_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign level = level_q;
endmodule

// ==== verilog/word_fifo.sv ====
// Purpose: Small valid/ready FIFO in the sample path.
// Assumes: Same clock on both sides.
// Notes: Full and empty come from an occupancy count.
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [AW:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = count_q != (AW+1)'(DEPTH);
  assign out_valid = count_q != '0;
  assign out_data = mem_q[rd_ptr_q];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== verilog/sample_block_output_formatter.sv ====
// Purpose: Formats samples into blocks, buffers them, and drains them
//          to the backplane register port or the local byte stream.
// Assumes: Samples arrive on sys_clk from the filter chain; arm and
//          trigger pins are asynchronous.
// Notes: AHB-Lite slave with zero wait states, response always OKAY.
`timescale 1ns/1ps
module sample_block_output_formatter #(
  parameter logic [fmt_pkg::DLY_W-1:0] DELAY_MIN = fmt_pkg::DELAY_MIN_DEF,
  parameter logic [fmt_pkg::DLY_W-1:0] DELAY_MAX = fmt_pkg::DELAY_MAX_DEF,
  parameter int FIFO_DEPTH = fmt_pkg::FIFO_DEPTH_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sample_valid,
  input wire logic [fmt_pkg::SAMPLE_W-1:0] sample_re,
  input wire logic [fmt_pkg::SAMPLE_W-1:0] sample_im,
  input wire logic arm_pin,
  input wire logic trig_pin,
  input wire logic lbus_ready,
  output logic [7:0] lbus_data,
  output logic lbus_valid
);
  import fmt_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic cfg_complex_q, cfg_res24_q, cfg_cont_q, cfg_local_q;
  logic [BS_W-1:0] bs_req_q, bs_eff_q;
  logic setup_err_q;
  logic [DLY_W-1:0] delay_q;
  logic wr_pend_q;
  logic [7:0] wr_off_q;
  logic hreadyout_q, hresp_q;
  logic [31:0] hrdata_q;
  logic arm_lvl, trig_lvl, arm_prev_q, trig_prev_q;
  acq_state_t acq_q;
  logic [31:0] smp_cnt_q;
  logic blk_avail_q, ovf_q;
  logic hold_vld_q, fmt_phase_q;
  logic [SAMPLE_W-1:0] hold_re_q, hold_im_q;
  logic fifo_in_ready, fifo_out_valid, ser_load;
  logic [SAMPLE_W-1:0] fifo_in_data, fifo_out_data;
  logic [SAMPLE_W-1:0] ser_word_q;
  logic [1:0] ser_left_q;
  logic [7:0] lbus_data_q;
  logic lbus_valid_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire ahb_take = hsel && hready && htrans[1];
  wire rd_take = ahb_take && !hwrite;
  wire [7:0] rd_off = haddr[7:0];
  wire wr_cfg = wr_pend_q && (wr_off_q == REG_CONFIG);
  wire wr_bs = wr_pend_q && (wr_off_q == REG_BLKSIZE);
  wire wr_dly = wr_pend_q && (wr_off_q == REG_DELAY);
  wire wr_ctl = wr_pend_q && (wr_off_q == REG_CONTROL);
  wire arm_sw = wr_ctl && hwdata[CTL_ARM_BIT];
  wire trig_sw = wr_ctl && hwdata[CTL_TRIG_BIT];
  wire rd_pop = rd_take && (rd_off == REG_DATA) && !cfg_local_q;

  // ----------------------------------------------------------------
  // Block size limits
  // ----------------------------------------------------------------
  wire [1:0] lim_sel = {cfg_complex_q, cfg_res24_q};
  wire [BS_W-1:0] bs_min = (lim_sel == 2'b00) ? BS_MIN_R12 :
                           (lim_sel == 2'b11) ? BS_MIN_C24 : BS_MIN_MID;
  wire [BS_W-1:0] bs_max = (lim_sel == 2'b00) ? BS_MAX_R12 :
                           (lim_sel == 2'b11) ? BS_MAX_C24 : BS_MAX_MID;
  wire bs_in_abs = (bs_req_q >= BS_ABS_MIN) && (bs_req_q <= BS_ABS_MAX);
  wire bs_in_fmt = (bs_req_q >= bs_min) && (bs_req_q <= bs_max);
  wire bs_req_ok = bs_in_abs && bs_in_fmt && !bs_req_q[0];

  wire [DLY_W-1:0] dly_wr = hwdata[DLY_W-1:0];
  wire [DLY_W-1:0] dly_clamped = (dly_wr < DELAY_MIN) ? DELAY_MIN :
                                 (dly_wr > DELAY_MAX) ? DELAY_MAX : dly_wr;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] cfg_word = {28'h000_0000, cfg_local_q, cfg_cont_q,
                          cfg_res24_q, cfg_complex_q};
  wire [31:0] st_word = {25'h000_0000, setup_err_q, 1'b0,
                         fifo_out_valid, ovf_q, acq_q == ACQ_RUN,
                         acq_q == ACQ_ARMED, blk_avail_q};
  wire [31:0] data_word = (fifo_out_valid && !cfg_local_q) ?
                          {8'h00, fifo_out_data} : 32'h0000_0000;
  wire [31:0] rd_mux = (rd_off == REG_CONFIG) ? cfg_word :
                       (rd_off == REG_BLKSIZE) ? {7'h00, bs_eff_q} :
                       (rd_off == REG_DELAY) ? {8'h00, delay_q} :
                       (rd_off == REG_STATUS) ? st_word :
                       (rd_off == REG_DATA) ? data_word : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_off_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= ahb_take && hwrite;
      wr_off_q <= haddr[7:0];
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      if (rd_take) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      {cfg_local_q, cfg_cont_q, cfg_res24_q, cfg_complex_q} <= CFG_RESET;
      bs_req_q <= BS_RESET;
      delay_q <= DELAY_MIN;
    end else begin
      if (wr_cfg) begin
        {cfg_local_q, cfg_cont_q, cfg_res24_q, cfg_complex_q} <= hwdata[3:0];
      end
      if (wr_bs) begin
        bs_req_q <= hwdata[BS_W-1:0];
      end
      if (wr_dly) begin
        delay_q <= dly_clamped;
      end
    end
  end

  // The request is rechecked every cycle, so a later type or
  // resolution change can make a parked request valid.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bs_eff_q <= BS_RESET;
      setup_err_q <= 1'b0;
    end else if (bs_req_ok) begin
      bs_eff_q <= bs_req_q;
      setup_err_q <= 1'b0;
    end else begin
      setup_err_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Arm and trigger
  // ----------------------------------------------------------------
  pin_sync arm_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin(arm_pin),
    .level(arm_lvl)
  );

  pin_sync trig_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin(trig_pin),
    .level(trig_lvl)
  );

  wire arm_ev = arm_sw || (arm_lvl && !arm_prev_q);
  wire trig_ev = trig_sw || (trig_lvl && !trig_prev_q);

  // ----------------------------------------------------------------
  // Formatter
  // ----------------------------------------------------------------
  // Keep 24 bits or the top 12.
  wire [SAMPLE_W-1:0] re_fmt = cfg_res24_q ? sample_re : {12'h000, sample_re[23:12]};
  wire [SAMPLE_W-1:0] im_fmt = cfg_res24_q ? sample_im : {12'h000, sample_im[23:12]};
  wire fifo_push = hold_vld_q && fifo_in_ready;
  // Real output ends after one word.
  wire last_push = fifo_push && (fmt_phase_q || !cfg_complex_q);
  wire running = acq_q == ACQ_RUN;
  wire take_smp = sample_valid && running && (!hold_vld_q || last_push);
  wire ovf_ev = sample_valid && running && !take_smp;
  assign fifo_in_data = fmt_phase_q ? hold_im_q : hold_re_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hold_vld_q <= 1'b0;
      fmt_phase_q <= 1'b0;
      hold_re_q <= 24'h00_0000;
      hold_im_q <= 24'h00_0000;
    end else if (take_smp) begin
      hold_vld_q <= 1'b1;
      fmt_phase_q <= 1'b0;
      hold_re_q <= re_fmt;
      hold_im_q <= im_fmt;
    end else if (last_push) begin
      hold_vld_q <= 1'b0;
      fmt_phase_q <= 1'b0;
    end else if (fifo_push) begin
      fmt_phase_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Acquisition control
  // ----------------------------------------------------------------
  // One count per real value or complex pair.
  wire [31:0] cnt_nxt = smp_cnt_q + 32'h0000_0001;
  // Block mode ends at block size.
  wire blk_done = take_smp && !cfg_cont_q && (cnt_nxt == {7'h00, bs_eff_q});
  // Delay only counts in continuous mode.
  wire [31:0] avail_thr = {7'h00, bs_eff_q} + (cfg_cont_q ? {8'h00, delay_q} : 32'h0000_0000);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acq_q <= ACQ_IDLE;
      arm_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      arm_prev_q <= arm_lvl;
      trig_prev_q <= trig_lvl;
      unique case (acq_q)
        ACQ_IDLE: begin
          if (arm_ev) begin
            acq_q <= ACQ_ARMED;
          end
        end
        ACQ_ARMED: begin
          if (trig_ev) begin
            acq_q <= ACQ_RUN;
          end
        end
        ACQ_RUN: begin
          if (blk_done || ovf_ev) begin
            acq_q <= ACQ_IDLE;
          end
        end
        default: begin
          acq_q <= ACQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      smp_cnt_q <= 32'h0000_0000;
      blk_avail_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (arm_ev && acq_q == ACQ_IDLE) begin
      smp_cnt_q <= 32'h0000_0000;
      blk_avail_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (take_smp) begin
        smp_cnt_q <= cnt_nxt;
      end
      if (take_smp && cnt_nxt >= avail_thr) begin
        blk_avail_q <= 1'b1;
      end
      if (ovf_ev) begin
        ovf_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffer and output ports
  // ----------------------------------------------------------------
  // Stands in for the 18 Mbyte store.
  word_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) out_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(hold_vld_q),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(rd_pop || ser_load),
    .out_data(fifo_out_data)
  );

  // Both ports drain the same formatted words.
  wire byte_adv = !lbus_valid_q || lbus_ready;
  assign ser_load = byte_adv && (ser_left_q == 2'd0) && cfg_local_q && fifo_out_valid;
  wire [SAMPLE_W-1:0] ser_aligned = cfg_res24_q ? fifo_out_data : {fifo_out_data[15:0], 8'h00};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ser_word_q <= 24'h00_0000;
      ser_left_q <= 2'd0;
      lbus_data_q <= 8'h00;
      lbus_valid_q <= 1'b0;
    end else if (byte_adv) begin
      if (ser_left_q != 2'd0) begin
        lbus_data_q <= ser_word_q[23:16];
        ser_word_q <= {ser_word_q[15:0], 8'h00};
        ser_left_q <= ser_left_q - 2'd1;
        lbus_valid_q <= 1'b1;
      end else if (ser_load) begin
        lbus_data_q <= ser_aligned[23:16];
        ser_word_q <= {ser_aligned[15:0], 8'h00};
        ser_left_q <= cfg_res24_q ? 2'd2 : 2'd1;
        lbus_valid_q <= 1'b1;
      end else begin
        lbus_valid_q <= 1'b0;
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign lbus_data = lbus_data_q;
  assign lbus_valid = lbus_valid_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence cpx_real_s;
    fifo_push && !fmt_phase_q && cfg_complex_q;
  endsequence

  sequence blk_end_s;
    blk_done;
  endsequence

  setup_err_hold_a: assert property (!bs_req_ok |=> setup_err_q && $stable(bs_eff_q))
    else $error("invalid block size changed size or left flag clear");
  bs_update_a: assert property (bs_req_ok |=> bs_eff_q == $past(bs_req_q) && !setup_err_q)
    else $error("valid block size not adopted");
  bs_even_a: assert property (!bs_eff_q[0])
    else $error("block size in use is odd");
  bs_window_a: assert property (bs_eff_q >= BS_ABS_MIN && bs_eff_q <= BS_ABS_MAX)
    else $error("block size in use outside overall window");
  delay_bound_a: assert property (delay_q >= DELAY_MIN && delay_q <= DELAY_MAX)
    else $error("delay outside bounds");
  cpx_order_a: assert property (cpx_real_s |=> hold_vld_q && fmt_phase_q)
    else $error("imaginary word does not follow real word");
  real_only_a: assert property (fifo_push && !cfg_complex_q |-> !fmt_phase_q ##1 !fmt_phase_q)
    else $error("imaginary word pushed in real mode");
  res12_a: assert property (take_smp && !cfg_res24_q |=> !(|{hold_re_q[23:12], hold_im_q[23:12]}))
    else $error("12-bit word has upper bits set");
  blk_stop_a: assert property (blk_end_s |=> acq_q == ACQ_IDLE && blk_avail_q ##1 !take_smp)
    else $error("block mode did not stop after a block");
  ovf_stop_a: assert property (ovf_ev |=> ovf_q && acq_q == ACQ_IDLE)
    else $error("overflow did not stop acquisition");
endmodule

// ==== verification/byte_sink.sv ====
// Purpose: Local byte stream sink that stalls at random.
// Assumes: Same clock as the formatter.
// Notes: Accepted bytes are queued in got for the bench.
`timescale 1ns/1ps
module byte_sink (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic lbus_valid,
  input wire logic [7:0] lbus_data,
  output logic lbus_ready
);
  logic [7:0] got[$];
  always @(posedge sys_clk) begin
    if (!reset && lbus_valid && lbus_ready) begin
      got.push_back(lbus_data);
    end
    // Stalling a third of the time keeps the word buffer under pressure.
    lbus_ready <= ($urandom % 3) != 0;
  end
endmodule

// ==== verification/sample_block_output_formatter_tb.sv ====
// Purpose: Self-checking bench for the sample block output formatter.
// Assumes: Delay bounds shortened to 4 and 256 samples.
// Notes: Expected words and sizes are modelled by bench functions.
`timescale 1ns/1ps
module sample_block_output_formatter_tb;
  import fmt_pkg::*;
  localparam logic [23:0] DMIN = 24'h00_0004;
  localparam logic [23:0] DMAX = 24'h00_0100;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic sample_valid = 1'b0;
  logic arm_pin = 1'b0;
  logic trig_pin = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [SAMPLE_W-1:0] sample_re = 24'h00_0000;
  logic [SAMPLE_W-1:0] sample_im = 24'h00_0000;
  logic [31:0] hrdata, rd;
  logic hready, hresp, lbus_ready, lbus_valid;
  logic [7:0] lbus_data;
  logic [3:0] cfg;
  logic [24:0] req, cur, b;
  logic [23:0] d;
  logic [23:0] q[$];
  int n_errors = 0;
  int checked = 0;

  always #5 sys_clk = ~sys_clk;

  sample_block_output_formatter #(.DELAY_MIN(DMIN), .DELAY_MAX(DMAX), .FIFO_DEPTH(4)) DUT (
    .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .sample_valid(sample_valid), .sample_re(sample_re),
    .sample_im(sample_im), .arm_pin(arm_pin), .trig_pin(trig_pin), .lbus_ready(lbus_ready),
    .lbus_data(lbus_data), .lbus_valid(lbus_valid));

  byte_sink sink (.sys_clk(sys_clk), .reset(reset), .lbus_valid(lbus_valid),
    .lbus_data(lbus_data), .lbus_ready(lbus_ready));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  task stchk(input string nm, input int bit_n, input logic e);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    chk(nm, 32'(e), 32'(rd[bit_n]));
  endtask

  function logic [24:0] lim(input logic [3:0] c, input logic top);
    case (c[1:0])
      2'b00: return top ? BS_MAX_R12 : BS_MIN_R12;
      2'b11: return top ? BS_MAX_C24 : BS_MIN_C24;
      default: return top ? BS_MAX_MID : BS_MIN_MID;
    endcase
  endfunction

  function logic bs_ok(input logic [3:0] c, input logic [24:0] v);
    return !v[0] && v >= lim(c, 1'b0) && v <= lim(c, 1'b1) && v >= BS_ABS_MIN && v <= BS_ABS_MAX;
  endfunction

  function logic [31:0] wexp(input logic [23:0] v);
    return cfg[1] ? {8'h00, v} : {20'h0_0000, v[23:12]};
  endfunction

  task setup(input logic [3:0] c, input logic [24:0] v);
    cfg = c;
    bus(1'b1, REG_CONFIG, {28'h000_0000, c});
    if (bs_ok(cfg, req)) cur = req;
    req = v;
    bus(1'b1, REG_BLKSIZE, {7'h00, v});
    if (bs_ok(cfg, req)) cur = req;
    // The size in use follows a valid request one edge after the write lands.
    @(posedge sys_clk);
  endtask

  task samp;
    sample_valid <= 1'b1;
    sample_re <= 24'($urandom);
    sample_im <= cfg[0] ? 24'($urandom) : 24'h00_0000;
    @(posedge sys_clk);
    q.push_back(sample_re);
    if (cfg[0]) q.push_back(sample_im);
    sample_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task pop_chk;
    rchk("data word", REG_DATA, wexp(q.pop_front()));
  endtask

  task end_sim;
    $display("Counts: %0d checked, %0d errors", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    $display("Error watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    void'($urandom(32'hb632));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rchk("config", REG_CONFIG, 32'h0000_0000);
    rchk("blksize", REG_BLKSIZE, {7'h00, BS_RESET});
    rchk("delay", REG_DELAY, {8'h00, DMIN});
    rchk("unmapped", 8'h40, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, 32'(hresp));
    $display("Test reset done");
    cfg = 4'h0;
    req = BS_RESET;
    cur = BS_RESET;
    // Each format meets its bounds, one step outside them, odd and random requests.
    for (int i = 0; i < 24; i++) begin
      case (i / 4)
        0: b = lim(4'(i % 4), 1'b0) + 25'(lim(4'(i % 4), 1'b0) & 1);
        1: b = lim(4'(i % 4), 1'b0) - 25'h000_0001;
        2: b = lim(4'(i % 4), 1'b1);
        3: b = lim(4'(i % 4), 1'b1) + 25'h000_0002;
        4: b = 25'($urandom % lim(4'(i % 4), 1'b1)) & ~25'h000_0001;
        default: b = 25'($urandom) | 25'h000_0001;
      endcase
      setup(4'(i % 4), b);
      rchk("blksize", REG_BLKSIZE, {7'h00, cur});
      stchk("setup error", ST_SETUP_ERR_BIT, !bs_ok(cfg, req));
    end
    $display("Test block size done");
    for (int j = 0; j < 3; j++) begin
      d = (j == 0) ? 24'h00_0000 : (j == 1) ? 24'hFF_FFFF : DMIN + 24'($urandom % 253);
      bus(1'b1, REG_DELAY, {8'h00, d});
      rchk("delay", REG_DELAY, {8'h00, (d < DMIN) ? DMIN : (d > DMAX) ? DMAX : d});
    end
    $display("Test delay done");
    setup(4'h3, 25'h000_0002);
    bus(1'b1, REG_CONTROL, 32'h0000_0001);
    bus(1'b1, REG_CONTROL, 32'h0000_0002);
    repeat (2) samp();
    stchk("avail", ST_AVAIL_BIT, 1'b1);
    stchk("running", ST_RUN_BIT, 1'b0);
    repeat (4) pop_chk();
    bus(1'b1, REG_CONTROL, 32'h0000_0002);
    samp();
    q.delete();
    stchk("data ready", ST_DATA_BIT, 1'b0);
    $display("Test complex block done");
    setup(4'h0, 25'h000_0006);
    bus(1'b1, REG_CONTROL, 32'h0000_0001);
    bus(1'b1, REG_CONTROL, 32'h0000_0002);
    for (int i = 0; i < 6; i++) begin
      samp();
      pop_chk();
    end
    stchk("avail", ST_AVAIL_BIT, 1'b1);
    $display("Test real block done");
    setup(4'h4, 25'h000_0006);
    bus(1'b1, REG_DELAY, {8'h00, DMIN});
    bus(1'b1, REG_CONTROL, 32'h0000_0001);
    bus(1'b1, REG_CONTROL, 32'h0000_0002);
    for (int i = 1; i <= 12; i++) begin
      samp();
      pop_chk();
      stchk("avail", ST_AVAIL_BIT, i >= 6 + DMIN);
    end
    repeat (10) samp();
    stchk("overflow", ST_OVF_BIT, 1'b1);
    stchk("running", ST_RUN_BIT, 1'b0);
    // Four buffered words and the held one survive the overflow.
    repeat (5) pop_chk();
    q.delete();
    stchk("data ready", ST_DATA_BIT, 1'b0);
    $display("Test continuous done");
    // Four 24-bit words give three bytes each, six 12-bit words two each.
    for (int k = 0; k < 2; k++) begin
      setup(k ? 4'h8 : 4'hA, k ? 25'h000_0006 : 25'h000_0004);
      arm_pin <= 1'b1;
      repeat (8) @(posedge sys_clk);
      stchk("overflow", ST_OVF_BIT, 1'b0);
      trig_pin <= 1'b1;
      repeat (8) @(posedge sys_clk);
      arm_pin <= 1'b0;
      trig_pin <= 1'b0;
      repeat (k ? 6 : 4) samp();
      for (int t = 0; t < 500 && sink.got.size() < 12; t++) @(posedge sys_clk);
      chk("byte count", 32'd12, 32'(sink.got.size()));
      while (q.size() > 0 && sink.got.size() >= 2) begin
        rd = wexp(q.pop_front());
        if (cfg[1]) begin
          chk("byte hi", {24'h00_0000, rd[23:16]}, {24'h00_0000, sink.got.pop_front()});
        end
        chk("byte mid", {24'h00_0000, rd[15:8]}, {24'h00_0000, sink.got.pop_front()});
        chk("byte lo", {24'h00_0000, rd[7:0]}, {24'h00_0000, sink.got.pop_front()});
      end
    end
    rchk("data local", REG_DATA, 32'h0000_0000);
    $display("Test byte port done");
    end_sim();
  end
endmodule
